// ### logic/bscan_pkg.sv
// shared constants and types for the boundary-scan instruction decoder
package bscan_pkg;

  // instruction register geometry and opcodes
  localparam int          IR_W        = 4;
  localparam logic [3:0]  IR_EXTEST   = 4'h0;
  localparam logic [3:0]  IR_IDCODE   = 4'h1;
  localparam logic [3:0]  IR_SAMPLE   = 4'h2;
  localparam logic [3:0]  IR_CORE_RST = 4'hC;  // core_reset_instr
  localparam logic [3:0]  IR_BYPASS   = 4'hF;
  localparam logic [3:0]  IR_RESET    = IR_IDCODE; // power-up instruction
  localparam logic [3:0]  IR_CAPTURE  = 4'h1;  // fixed capture-ir pattern

  // identification word layout
  localparam int          ID_W        = 32;
  localparam int          VER_W       = 4;
  localparam int          PART_W      = 16;
  localparam int          MFR_W       = 11;
  localparam logic [0:0]  ID_LSB      = 1'h1;

  // boundary cell layout per pin, lsb nearest tdo
  localparam int          CELL_W      = 4;
  localparam int          CELL_ID     = 0;   // input data
  localparam int          CELL_OD     = 1;   // output data
  localparam int          CELL_OC     = 2;   // output control
  localparam int          CELL_PUD    = 3;   // pull-up disable

  // depth of the pin synchronisers
  localparam int          SYNC_W      = 2;

  // tap controller states, gray coded in listing order
  typedef enum logic [3:0] {
    TAP_RESET    = 4'h0,
    TAP_IDLE     = 4'h1,
    TAP_SEL_DR   = 4'h3,
    TAP_CAP_DR   = 4'h2,
    TAP_SH_DR    = 4'h6,
    TAP_EX1_DR   = 4'h7,
    TAP_PAUSE_DR = 4'h5,
    TAP_EX2_DR   = 4'h4,
    TAP_UPD_DR   = 4'hC,
    TAP_SEL_IR   = 4'hD,
    TAP_CAP_IR   = 4'hF,
    TAP_SH_IR    = 4'hE,
    TAP_EX1_IR   = 4'hA,
    TAP_PAUSE_IR = 4'hB,
    TAP_EX2_IR   = 4'h9,
    TAP_UPD_IR   = 4'h8
  } tap_state_e;

  // data register chosen by the current instruction
  typedef enum logic [1:0] {
    SEL_BYPASS = 2'h0,
    SEL_ID     = 2'h1,
    SEL_BSR    = 2'h3,
    SEL_RST    = 2'h2
  } dr_sel_e;

endpackage

// ### logic/tap_ctrl_fsm.sv
// sixteen-state test access port controller, stepped on tck rising edges
`timescale 1ns/100ps
module tap_ctrl_fsm
  import bscan_pkg::*;
(
  input  wire logic                 core_clk_in,  // system clock
  input  wire logic                 reset_in,     // async reset, high
  input  wire logic                 tck_rise_in,  // one-cycle tck rise
  input  wire logic                 tms_in,       // synchronised tms
  output bscan_pkg::tap_state_e     state_out     // current tap state
);
  import bscan_pkg::*;

  // whole state of this module
  typedef struct packed {
    tap_state_e st;  // controller state
  } fsm_s;

  fsm_s q;  // registered state
  fsm_s d;  // next state

  // next-state table, moves only on a tck rise
  always_comb
  begin
    d = q;
    if (tck_rise_in)
    begin
      case (q.st)
        TAP_RESET:    d.st = tms_in ? TAP_RESET  : TAP_IDLE;
        TAP_IDLE:     d.st = tms_in ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_DR:   d.st = tms_in ? TAP_SEL_IR : TAP_CAP_DR;
        TAP_CAP_DR:   d.st = tms_in ? TAP_EX1_DR : TAP_SH_DR;
        TAP_SH_DR:    d.st = tms_in ? TAP_EX1_DR : TAP_SH_DR;
        TAP_EX1_DR:   d.st = tms_in ? TAP_UPD_DR : TAP_PAUSE_DR;
        TAP_PAUSE_DR: d.st = tms_in ? TAP_EX2_DR : TAP_PAUSE_DR;
        TAP_EX2_DR:   d.st = tms_in ? TAP_UPD_DR : TAP_SH_DR;
        TAP_UPD_DR:   d.st = tms_in ? TAP_SEL_DR : TAP_IDLE;
        TAP_SEL_IR:   d.st = tms_in ? TAP_RESET  : TAP_CAP_IR;
        TAP_CAP_IR:   d.st = tms_in ? TAP_EX1_IR : TAP_SH_IR;
        TAP_SH_IR:    d.st = tms_in ? TAP_EX1_IR : TAP_SH_IR;
        TAP_EX1_IR:   d.st = tms_in ? TAP_UPD_IR : TAP_PAUSE_IR;
        TAP_PAUSE_IR: d.st = tms_in ? TAP_EX2_IR : TAP_PAUSE_IR;
        TAP_EX2_IR:   d.st = tms_in ? TAP_UPD_IR : TAP_SH_IR;
        TAP_UPD_IR:   d.st = tms_in ? TAP_SEL_DR : TAP_IDLE;
        default:      d.st = TAP_RESET;  // illegal code recovers
      endcase
    end
  end

  // state register
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q <= '{st: TAP_RESET};
    end
    else
    begin
      q <= d;
    end
  end

  assign state_out = q.st;

endmodule

// ### logic/boundary_scan_instruction_decode.sv
// boundary-scan instruction decode and data register selection
// Summary of operation
// - four-bit instruction register, sixteen codes
// - no highz; core reset floats outputs
// - lsb shifted in and out first
// - code 0x0 selects boundary chain
// - chain holds pull-up, control, data, analog
// - extest drives latched outputs immediately
// - extest capture samples external pins
// - shift-dr advances chain one bit
// - extest update-dr drives latches onto pins
// - code 0x1 selects 32-bit identification
// - identification is power-up instruction
// - idcode capture loads id, shifts out
// - code 0x2 preloads, pins stay functional
// - code 0xC selects unlatched core reset
// - code 0xF bypass, captures zero
// - id word: version, part, maker, one
`timescale 1ns/100ps
module boundary_scan_instruction_decode
  import bscan_pkg::*;
#(
  parameter int                PIN_N      = 8,      // scanned port pins
  parameter int                ANA_N      = 2,      // analog control bits
  parameter logic [3:0]        ID_VERSION = 4'h0,   // arbitrary value
  parameter logic [15:0]       ID_PART    = 16'h5A3C, // arbitrary value
  parameter logic [10:0]       ID_MFR     = 11'h2B1   // arbitrary value
)
(
  input  wire logic               core_clk_in,     // 125 mhz clock
  input  wire logic               reset_in,        // async reset, high
  input  wire logic               tck_in,          // tester clock pin
  input  wire logic               tms_in,          // tester mode pin
  input  wire logic               tdi_in,          // tester data in
  output logic                    tdo_out,         // tester data out
  output logic                    tdo_oe_out,      // tdo drive enable
  input  wire logic [PIN_N-1:0]   pin_in,          // pad input levels
  input  wire logic [PIN_N-1:0]   core_do_in,      // core output data
  input  wire logic [PIN_N-1:0]   core_oe_in,      // core output enable
  input  wire logic [PIN_N-1:0]   core_pullup_in,  // core pull-up enable
  input  wire logic [ANA_N-1:0]   core_ana_in,     // core analog control
  output logic      [PIN_N-1:0]   pin_do_out,      // pad output data
  output logic      [PIN_N-1:0]   pin_oe_out,      // pad output enable
  output logic      [PIN_N-1:0]   pin_pullup_out,  // pad pull-up enable
  output logic      [ANA_N-1:0]   ana_ctrl_out,    // analog control
  output logic                    core_reset_out,  // holds core in reset
  output logic      [IR_W-1:0]    instr_out        // active instruction
);
  import bscan_pkg::*;

  // chain length: four cells per pin, analog cells above them;
  // pin 0 input cell sits at bit 0, nearest tdo, so it leaves first
  // and the analog cells are the last bits a tester reads
  localparam int CH_W = CELL_W * PIN_N + ANA_N;

  // full id word, bit zero fixed high
  localparam logic [ID_W-1:0] ID_WORD =
    {ID_VERSION, ID_PART, ID_MFR, ID_LSB};

  // state of the block bar the tap controller; synchronisers, shift stages and pad
  // flops share one register process so reset reaches every bit
  // the same way and no bit has a second writer
  typedef struct packed {
    logic [SYNC_W:0]     tck_s;    // tck sync plus one history stage
    logic [SYNC_W-1:0]   tms_s;    // tms synchroniser
    logic [SYNC_W-1:0]   tdi_s;    // tdi synchroniser
    logic [PIN_N-1:0]    pin_s1;   // pad sync, first stage
    logic [PIN_N-1:0]    pin_s2;   // pad sync, second stage
    logic [IR_W-1:0]     ir_sh;    // instruction shift stage
    logic [IR_W-1:0]     ir;       // active instruction
    logic [CH_W-1:0]     bsr_sh;   // boundary chain shift stage
    logic [CH_W-1:0]     bsr_upd;  // boundary chain output latches
    logic [ID_W-1:0]     id_sh;    // identification shift stage
    logic                byp;      // bypass cell
    logic                rst_bit;  // core reset cell
    logic                tdo;      // tdo level
    logic                tdo_oe;   // tdo enable
    logic [PIN_N-1:0]    do_o;     // registered pad data
    logic [PIN_N-1:0]    oe_o;     // registered pad enable
    logic [PIN_N-1:0]    pu_o;     // registered pull-up
    logic [ANA_N-1:0]    ana_o;    // registered analog control
  } st_s;

  st_s           q;          // registered state
  st_s           d;          // next state
  tap_state_e    tap_st;     // tap controller state
  logic          tck_rise;   // one-cycle tck rising edge
  logic          tck_fall;   // one-cycle tck falling edge
  logic [CH_W-1:0] cap_vec;  // values captured into the chain
  logic [PIN_N-1:0] lat_od;  // latched output data per pin
  logic [PIN_N-1:0] lat_oc;  // latched output control per pin
  logic [PIN_N-1:0] lat_pud; // latched pull-up disable per pin
  dr_sel_e       dr_sel;     // data register in the path

  // edges seen only from stages past the first synchroniser flop;
  // tck runs far slower than core_clk_in, so sampling is safe;
  // limitation: each tck phase must span at least three core clocks
  // or an edge is lost, which caps tck near a sixth of the core rate
  assign tck_rise = q.tck_s[1] & ~q.tck_s[2];
  assign tck_fall = ~q.tck_s[1] & q.tck_s[2];

  // tap controller steps on each sampled tck rise
  tap_ctrl_fsm u_tap (
    .core_clk_in (core_clk_in),
    .reset_in    (reset_in),
    .tck_rise_in (tck_rise),
    .tms_in      (q.tms_s[1]),
    .state_out   (tap_st)
  );

  // per-pin cell wiring: capture sources and latched outputs;
  // the pull-up cell holds a disable, so the core's enable is
  // inverted on capture and inverted back on the way to the pad
  generate
    for (genvar i = 0; i < PIN_N; i++)
    begin : g_cell
      // pad level captured, not the core's view of it
      assign cap_vec[CELL_W*i+CELL_ID]  = q.pin_s2[i];
      assign cap_vec[CELL_W*i+CELL_OD]  = core_do_in[i];
      assign cap_vec[CELL_W*i+CELL_OC]  = core_oe_in[i];
      assign cap_vec[CELL_W*i+CELL_PUD] = ~core_pullup_in[i];
      assign lat_od[i]  = q.bsr_upd[CELL_W*i+CELL_OD];
      assign lat_oc[i]  = q.bsr_upd[CELL_W*i+CELL_OC];
      assign lat_pud[i] = q.bsr_upd[CELL_W*i+CELL_PUD];
    end
  endgenerate

  // analog interface cells sit above the pin cells
  assign cap_vec[CH_W-1 -: ANA_N] = core_ana_in;

  // instruction decode into a data register choice; decoding from
  // the active instruction, not the shift stage, keeps the path
  // steady while a new code is being shifted in
  always_comb
  begin
    case (q.ir)
      IR_EXTEST:   dr_sel = SEL_BSR;
      IR_SAMPLE:   dr_sel = SEL_BSR;
      IR_IDCODE:   dr_sel = SEL_ID;
      IR_CORE_RST: dr_sel = SEL_RST;
      IR_BYPASS:   dr_sel = SEL_BYPASS;
      // no highz code: any other opcode falls to bypass
      default:     dr_sel = SEL_BYPASS;
    endcase
  end

  // next-state logic for shifting, capture, update and pads
  always_comb
  begin
    d = q;

    // two-flop synchronisers for every pin-sourced input
    d.tck_s  = {q.tck_s[SYNC_W-1:0], tck_in};
    d.tms_s  = {q.tms_s[0], tms_in};
    d.tdi_s  = {q.tdi_s[0], tdi_in};
    d.pin_s1 = pin_in;
    d.pin_s2 = q.pin_s1;

    // work done on the tck rising edge, old tap state; the tap
    // module moves on this same clock, so tap_st is still the
    // state being left, as the capture and shift steps require
    if (tck_rise)
    begin
      case (tap_st)
        TAP_RESET:
        begin
          // logic reset returns to the identification path; the
          // reset cell is left alone, so a held core stays held
          d.ir = IR_RESET;
        end
        TAP_CAP_IR:
        begin
          d.ir_sh = IR_CAPTURE;
        end
        TAP_SH_IR:
        begin
          // new bit enters at the top, lsb leaves first
          d.ir_sh = {q.tdi_s[1], q.ir_sh[IR_W-1:1]};
        end
        TAP_CAP_DR:
        begin
          case (dr_sel)
            SEL_BSR:    d.bsr_sh = cap_vec;
            SEL_ID:     d.id_sh  = ID_WORD;
            SEL_BYPASS: d.byp    = 1'h0;
            // reset cell keeps its value so the hold survives
            default:    d.rst_bit = q.rst_bit;
          endcase
        end
        TAP_SH_DR:
        begin
          // one position per tck, tdi at msb, tdo from lsb
          case (dr_sel)
            SEL_BSR:
              d.bsr_sh = {q.tdi_s[1], q.bsr_sh[CH_W-1:1]};
            SEL_ID:
              d.id_sh = {q.tdi_s[1], q.id_sh[ID_W-1:1]};
            SEL_RST:
              d.rst_bit = q.tdi_s[1];
            default:
              d.byp = q.tdi_s[1];
          endcase
        end
        default:
        begin
          d.byp = q.byp;  // other states hold everything
        end
      endcase
    end

    // work done on the tck falling edge
    if (tck_fall)
    begin
      // tdo changes on the fall so the tester samples it on the rise;
      // a full half period of margin beats tracking the rise itself,
      // at the cost of tdo lagging the pin fall by three core clocks
      case (tap_st)
        TAP_SH_IR:
        begin
          d.tdo    = q.ir_sh[0];
          d.tdo_oe = 1'h1;
        end
        TAP_SH_DR:
        begin
          case (dr_sel)
            SEL_BSR: d.tdo = q.bsr_sh[0];
            SEL_ID:  d.tdo = q.id_sh[0];
            SEL_RST: d.tdo = q.rst_bit;
            default: d.tdo = q.byp;
          endcase
          d.tdo_oe = 1'h1;
        end
        TAP_UPD_IR:
        begin
          // the new code takes over only here, so a half-shifted
          // instruction never reaches the decode
          d.ir     = q.ir_sh;
          d.tdo_oe = 1'h0;
        end
        TAP_UPD_DR:
        begin
          // preload and extest both fill the output latches
          if (dr_sel == SEL_BSR)
          begin
            d.bsr_upd = q.bsr_sh;
          end
          d.tdo_oe = 1'h0;
        end
        default:
        begin
          d.tdo_oe = 1'h0;  // tdo floats outside shifting
        end
      endcase
    end

    // pad drive: latches only while extest is the active code,
    // so preload never disturbs the running core; the switch
    // follows instr one clock later, with no wait for an update
    // pass, which is why extest must be preceded by a preload
    if (q.ir == IR_EXTEST)
    begin
      d.do_o  = lat_od;
      d.oe_o  = lat_oc;
      d.pu_o  = ~lat_pud;
      d.ana_o = q.bsr_upd[CH_W-1 -: ANA_N];
    end
    else
    begin
      d.do_o  = core_do_in;
      d.oe_o  = core_oe_in;
      d.pu_o  = core_pullup_in;
      d.ana_o = core_ana_in;
    end
  end

  // single state register; reset loads constants only;
  // the instruction comes up as identification so a tester can
  // read the id word with no instruction scan first
  always_ff @(posedge core_clk_in or posedge reset_in)
  begin
    if (reset_in)
    begin
      q    <= '0;
      q.ir <= IR_RESET;
      q.ir_sh <= IR_RESET;
    end
    else
    begin
      q <= d;
    end
  end

  // every output straight from a flop; the pads therefore lag
  // their sources by one core clock, which a tester never sees
  // at tck rates the synchronisers allow
  assign tdo_out        = q.tdo;
  assign tdo_oe_out     = q.tdo_oe;
  assign pin_do_out     = q.do_o;
  assign pin_oe_out     = q.oe_o;
  assign pin_pullup_out = q.pu_o;
  assign ana_ctrl_out   = q.ana_o;
  // reset cell feeds the core directly, no update latch, so the
  // core sits in reset (pads tri-stated) while the bit is one
  assign core_reset_out = q.rst_bit;
  assign instr_out      = q.ir;

endmodule

// ### dv/bscan_tester.sv
// behavioural test-port tester that drives tck, tms and tdi
`timescale 1ns/100ps
module bscan_tester (
  input  wire logic core_clk_in, // bench clock, paces edges
  input  wire logic tdo_in,      // device serial out
  input  wire logic tdo_oe_in,   // device drives tdo
  output logic      tck_out,     // tester clock, low between frames
  output logic      tms_out,     // mode select
  output logic      tdi_out      // serial data
);
  localparam int HALF = 10;  // 80 ns half period
  logic tdo_seen;            // tdo as the wire shows it
  // undriven tdo floats, so a stale bit can never pass
  assign tdo_seen = tdo_oe_in ? tdo_in : 1'bx;
  initial
  begin
    tck_out = 1'b0;
    tms_out = 1'b1;
    tdi_out = 1'b0;
  end
  // one tck period; tdo sampled just before the rise
  task automatic step(input logic tms_v, input logic tdi_v,
                      output logic tdo_v);
    @(posedge core_clk_in);
    tms_out <= tms_v;
    tdi_out <= tdi_v;
    repeat (HALF) @(posedge core_clk_in);
    tdo_v = tdo_seen;
    tck_out <= 1'b1;
    repeat (HALF) @(posedge core_clk_in);
    tck_out <= 1'b0;
  endtask
endmodule

// ### dv/bscan_decode_assertions.sv
// port-level checks for the boundary-scan decoder
`timescale 1ns/100ps
module bscan_decode_chk
  import bscan_pkg::*;
#(
  parameter int PIN_N = 8, // scanned pins
  parameter int ANA_N = 2  // analog bits
)
(
  input wire logic             core_clk_in,    // clock
  input wire logic             reset_in,       // async reset
  input wire logic             tck_in,         // tester clock
  input wire logic             tdo_out,        // serial out
  input wire logic             tdo_oe_out,     // tdo enable
  input wire logic [PIN_N-1:0] core_do_in,     // core data
  input wire logic [PIN_N-1:0] core_oe_in,     // core enable
  input wire logic [PIN_N-1:0] core_pullup_in, // core pull-up
  input wire logic [ANA_N-1:0] core_ana_in,    // core analog
  input wire logic [PIN_N-1:0] pin_do_out,     // pad data
  input wire logic [PIN_N-1:0] pin_oe_out,     // pad enable
  input wire logic [PIN_N-1:0] pin_pullup_out, // pad pull-up
  input wire logic [ANA_N-1:0] ana_ctrl_out,   // analog out
  input wire logic             core_reset_out, // core reset
  input wire logic [IR_W-1:0]  instr_out       // instruction
);
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (reset_in);
  // core owns the pads; skip the edge after reset
  sequence func_mode;
    !$past(reset_in) && $past(instr_out) != IR_EXTEST;
  endsequence
  // latches own the pads for two clocks
  sequence held_extest;
    instr_out == IR_EXTEST ##1 instr_out == IR_EXTEST;
  endsequence
  // tck fall seen 2..8 clocks ago, sync delay included
  sequence fall_recent;
    !tck_in && !$past(tck_in, 2) && $past(tck_in, 8);
  endsequence
  // tck rise seen 2..8 clocks ago
  sequence rise_recent;
    tck_in && $past(tck_in, 2) && !$past(tck_in, 8);
  endsequence
  AST_IR_AT_RESET: assert property (
    $fell(reset_in) |-> instr_out == IR_IDCODE)
    else $error("instruction not identification after reset");
  AST_PAD_DATA: assert property (func_mode |->
    pin_do_out == $past(core_do_in))
    else $error("pad data not following core");
  AST_PAD_OE: assert property (func_mode |->
    pin_oe_out == $past(core_oe_in))
    else $error("pad enable not following core");
  AST_PAD_PU: assert property (func_mode |->
    pin_pullup_out == $past(core_pullup_in))
    else $error("pad pull-up not following core");
  AST_PAD_ANA: assert property (func_mode |->
    ana_ctrl_out == $past(core_ana_in))
    else $error("analog control not following core");
  AST_EXT_UPDATE: assert property (
    held_extest ##0 $changed(pin_do_out) |-> fall_recent)
    else $error("pad latch moved off an update fall");
  AST_TDO_FALL: assert property (
    $changed(tdo_out) |-> fall_recent)
    else $error("tdo moved away from a tck fall");
  AST_OE_FALL: assert property (
    $rose(tdo_oe_out) |-> fall_recent)
    else $error("tdo enable rose away from a tck fall");
  AST_CORE_RST: assert property (
    $changed(core_reset_out) |-> rise_recent)
    else $error("core reset moved away from a shift rise");
  AST_IR_FALL: assert property (
    $changed(instr_out) |-> fall_recent)
    else $error("instruction loaded away from a tck fall");
endmodule
bind boundary_scan_instruction_decode bscan_decode_chk #(
  .PIN_N(PIN_N), .ANA_N(ANA_N)) chk_u (
  .core_clk_in(core_clk_in), .reset_in(reset_in), .tck_in(tck_in),
  .tdo_out(tdo_out), .tdo_oe_out(tdo_oe_out), .core_do_in(core_do_in),
  .core_oe_in(core_oe_in), .core_pullup_in(core_pullup_in),
  .core_ana_in(core_ana_in), .pin_do_out(pin_do_out),
  .pin_oe_out(pin_oe_out), .pin_pullup_out(pin_pullup_out),
  .ana_ctrl_out(ana_ctrl_out), .core_reset_out(core_reset_out),
  .instr_out(instr_out));

// ### dv/tb_boundary_scan_instruction_decode.sv
// self-checking bench for the boundary-scan decoder
`timescale 1ns/100ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin \
  err_total++; $display("MISMATCH t=%0t got=%0h exp=%0h", \
  $time, g, e); end end
module tb_boundary_scan_instruction_decode;
  import bscan_pkg::*;
  localparam int          PN  = 4;         // scanned pins
  localparam int          AN  = 2;         // analog bits
  localparam int          CW  = 4*PN+AN;   // chain length
  localparam logic [3:0]  VER = 4'h2;      // arbitrary value
  localparam logic [15:0] PRT = 16'h4D71;  // arbitrary value
  localparam logic [10:0] MFR = 11'h155;   // arbitrary value
  localparam logic [4*PN-1:0] IMASK = {PN{4'h1}}; // input cells
  logic          core_clk_in = 1'b0;       // bench clock
  logic          reset_in = 1'b1;          // held at start
  logic          tck, tms, tdi, tdo, tdo_oe; // test port wires
  logic [PN-1:0] pin_in = '0, core_do = '0; // pad and core data
  logic [PN-1:0] core_oe = '0, core_pu = '0; // core drive
  logic [AN-1:0] core_ana = '0, ana;       // analog in and out
  logic [PN-1:0] pin_do, pin_oe, pin_pu;   // pad drive
  logic          core_rst;                 // core held in reset
  logic [3:0]    instr;                    // active instruction
  logic [63:0]   d, pre, nxt;              // scan data
  int            err_total = 0;            // mismatches
  int            samples_checked = 0;      // comparisons
  int            seed = 42433;             // fixed seed
  bit            mdl_q[$];                 // queue model of a dr path
  logic          exp_b;                    // model output bit
  always #4 core_clk_in = ~core_clk_in;    // 125 mhz
  boundary_scan_instruction_decode #(.PIN_N(PN), .ANA_N(AN),
    .ID_VERSION(VER), .ID_PART(PRT), .ID_MFR(MFR)) dut_u (
    .core_clk_in(core_clk_in), .reset_in(reset_in), .tck_in(tck),
    .tms_in(tms), .tdi_in(tdi), .tdo_out(tdo), .tdo_oe_out(tdo_oe),
    .pin_in(pin_in), .core_do_in(core_do), .core_oe_in(core_oe),
    .core_pullup_in(core_pu), .core_ana_in(core_ana),
    .pin_do_out(pin_do), .pin_oe_out(pin_oe), .pin_pullup_out(pin_pu),
    .ana_ctrl_out(ana), .core_reset_out(core_rst), .instr_out(instr));
  bscan_tester tst (.core_clk_in(core_clk_in), .tdo_in(tdo),
    .tdo_oe_in(tdo_oe), .tck_out(tck), .tms_out(tms), .tdi_out(tdi));
  // idle to idle through one dr or ir scan, lsb first
  task automatic scan(input bit ir, input int n, input logic [63:0] din,
                      output logic [63:0] dout);
    logic b;
    dout = '0;
    tst.step(1'b1, 1'b0, b);
    if (ir)
      tst.step(1'b1, 1'b0, b);
    tst.step(1'b0, 1'b0, b);
    tst.step(1'b0, 1'b0, b);
    for (int i = 0; i < n; i++)
    begin
      tst.step(i == n-1, din[i], b);
      dout[i] = b;
    end
    tst.step(1'b1, 1'b0, b);
    tst.step(1'b0, 1'b0, b);
  endtask
  // fresh random core and pad levels
  task automatic rnd();
    @(posedge core_clk_in);
    pin_in   <= PN'($random(seed));
    core_do  <= PN'($random(seed));
    core_oe  <= PN'($random(seed));
    core_pu  <= PN'($random(seed));
    core_ana <= AN'($random(seed));
  endtask
  // what capture should load into the pin cells
  function automatic logic [4*PN-1:0] cap_exp();
    logic [4*PN-1:0] v;
    for (int i = 0; i < PN; i++)
      v[4*i +: 4] = {~core_pu[i], core_oe[i], core_do[i], pin_in[i]};
    return v;
  endfunction
  // pads against latch contents l
  task automatic pads(input logic [63:0] l);
    for (int i = 0; i < PN; i++)
    begin
      `CHK(pin_do[i], l[4*i+1])
      `CHK(pin_oe[i], l[4*i+2])
      `CHK(pin_pu[i], ~l[4*i+3])
    end
    `CHK(ana, l[4*PN +: AN])
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // hang guard, several times the expected run
  initial
  begin
    #500000;
    err_total++;
    wrap_up();
  end
  initial
  begin
    repeat (4) @(posedge core_clk_in);
    reset_in <= 1'b0;
    repeat (2) @(posedge core_clk_in);
    `CHK(instr, IR_IDCODE)
    tst.step(1'b0, 1'b0, d[0]);
    scan(1'b0, 32, 64'($random(seed)), d);
    `CHK(d[31:0], {VER, PRT, MFR, ID_LSB})
    $display("test idcode done");
    // every opcode; unassigned ones must act as bypass
    for (int c = 0; c < 16; c++)
    begin
      scan(1'b1, 4, 64'(c), d);
      `CHK(d[3:0], IR_CAPTURE)
      `CHK(instr, 4'(c))
      if (!(c inside {0, 1, 2, 12}))
      begin
        pre = 64'($random(seed));
        mdl_q = {1'b0};  // capture puts zero in the one cell
        for (int i = 0; i < 2; i++)
          mdl_q.push_back(pre[i]);
        scan(1'b0, 2, pre, d);
        for (int i = 0; i < 2; i++)
        begin
          exp_b = mdl_q.pop_front();
          `CHK(d[i], exp_b)
        end
      end
    end
    $display("test opcodes done");
    scan(1'b1, 4, 64'(IR_CORE_RST), d);
    scan(1'b0, 1, 64'h1, d);
    `CHK(d[0], 1'b0)
    `CHK(core_rst, 1'b1)
    scan(1'b0, 1, 64'h0, d);
    `CHK(d[0], 1'b1)
    `CHK(core_rst, 1'b0)
    $display("test core reset done");
    rnd();
    scan(1'b1, 4, 64'(IR_SAMPLE), d);
    pre = {$random(seed), $random(seed)};
    scan(1'b0, CW, pre, d);
    `CHK(d[4*PN-1:0], cap_exp())
    `CHK(d[4*PN +: AN], core_ana)
    `CHK({pin_do, pin_oe, pin_pu}, {core_do, core_oe, core_pu})
    $display("test sample done");
    scan(1'b1, 4, 64'(IR_EXTEST), d);
    pads(pre);
    rnd();
    nxt = {$random(seed), $random(seed)};
    scan(1'b0, CW, nxt, d);
    `CHK(d[4*PN-1:0] & IMASK, cap_exp() & IMASK)
    pads(nxt);
    $display("test extest done");
    wrap_up();
  end
endmodule
